// ===== core/tass_pkg.sv
/*
  Shared constants and types of the touch converter serial sequencer.
  Assumes a host that clocks the serial link and drives select and data.
*/
package tass_pkg;

  // Command byte as it arrives, most significant bit first.
  typedef struct packed {
    logic       start;
    logic [2:0] channel_select;
    logic       res_8bit;
    logic       ref_mode_single_ended;
    logic       ref_power_sel;
    logic       adc_powerdown_sel;
  } tass_cmd_t;

  // Controls that go out to the analog part of the converter.
  typedef struct packed {
    logic ydrv_on;
    logic xp_pullup_en;
    logic adc_on;
    logic ref_on;
  } tass_ana_t;

  // Phase of the result readout on the falling clock edge.
  typedef enum logic [1:0] {
    TASS_IDLE,
    TASS_BUSY,
    TASS_DATA,
    TASS_TAIL
  } tass_phase_t;

  localparam int unsigned CMD_LEN   = 8;
  localparam int unsigned CNT_W     = 4;
  localparam int unsigned RES_HI    = 12;
  localparam int unsigned RES_LO    = 8;
  localparam logic [3:0]  ACQ_AT    = 4'h5;
  localparam logic [3:0]  CNT_LAST  = 4'h7;
  localparam logic [3:0]  CNT_ONE   = 4'h1;
  localparam logic [3:0]  CNT_ZERO  = 4'h0;
  localparam logic [3:0]  BITS_HI   = 4'hB;
  localparam logic [3:0]  BITS_LO   = 4'h7;
  localparam logic [7:0]  CMD_RST   = 8'h00;
  localparam logic [7:0]  POS_MASK  = 8'h3A;
  localparam int unsigned SY_CSN    = 0;
  localparam int unsigned SY_TOUCH  = 1;
  localparam int unsigned SY_MEAS   = 2;
  localparam int unsigned SY_CMD    = 3;
  localparam int unsigned SY_EOC    = 4;
  localparam int unsigned SY_W      = 5;
  localparam logic [4:0]  SY_RST    = 5'h01;

endpackage : tass_pkg

// ===== core/tass_core.sv
/*
  Serial command sequencer, result readout and pen-touch logic of a
  four-wire touch converter.
  Assumes the host clocks serial_shift_clock only with chip select low and
  launches din on falling edges; conv_code is held stable by the SAR.
*/
`timescale 1ns/1ps

module tass_core #(
  parameter logic [7:0] POS_CHAN_MASK = tass_pkg::POS_MASK
) (
  input  wire logic                 ref_clk,
  input  wire logic                 resetn,
  input  wire logic                 serial_shift_clock,
  input  wire logic                 cs_n,
  input  wire logic                 din,
  input  wire logic                 touch_sense,
  input  wire logic [11:0]          conv_code,
  output logic                      dout,
  output logic                      dout_oe_n,
  output logic                      busy,
  output logic                      busy_oe_n,
  output logic                      pen_touch_irq_n,
  output tass_pkg::tass_ana_t       ana,
  output logic [2:0]                channel_select,
  output logic                      ref_mode_single_ended
);

  logic                  link_rst, cfg_rst, rx_done, eoc_pulse, conv_start;
  logic [3:0]            rx_cnt_q, rx_cnt_d, fcnt_q, fcnt_d;
  logic [6:0]            rx_sh_q, rx_sh_d;
  tass_pkg::tass_cmd_t   cmd_q, cmd_d, cap_q, cap_d;
  logic                  cmd_tog_q, cmd_tog_d, seen_tog_q, seen_tog_d;
  tass_pkg::tass_phase_t phase_q, phase_d;
  logic [11:0]           fsh_q, fsh_d;
  logic                  diff_q, diff_d, dout_q, dout_d;
  logic                  busy_q, busy_d, meas_q, meas_d;
  logic                  eoc_tog_q, eoc_tog_d;
  logic [4:0]            sy1_q, sy2_q, sy_d;
  logic                  cmdt_q, eoct_q, cmd_evt, eoc_evt;
  logic                  cs_s, touch_s, meas_s, pos_chan;
  logic                  pen_en_q, pen_en_d, startup_q, startup_d;
  logic                  irq_q, irq_d;
  tass_pkg::tass_ana_t   ana_q, ana_d;

  // Select high or reset clears the link logic without waiting for a clock.
  assign link_rst = cs_n | ~resetn;
  assign cfg_rst  = ~resetn;

  // Command receiver on the rising edge.
  always_comb begin
    rx_cnt_d = rx_cnt_q;
    rx_sh_d  = rx_sh_q;
    rx_done  = 1'b0;
    if (rx_cnt_q == tass_pkg::CNT_ZERO) begin
      if (din) begin
        rx_cnt_d = tass_pkg::CNT_ONE;
        rx_sh_d  = {6'h00, din};
      end
    end else begin
      rx_sh_d = {rx_sh_q[5:0], din};
      if (rx_cnt_q == tass_pkg::CNT_LAST) begin
        rx_cnt_d = tass_pkg::CNT_ZERO;
        rx_done  = 1'b1;
      end else begin
        rx_cnt_d = rx_cnt_q + tass_pkg::CNT_ONE;
      end
    end
  end

  always_ff @(posedge serial_shift_clock or posedge link_rst) begin
    if (link_rst) begin
      rx_cnt_q <= tass_pkg::CNT_ZERO;
      rx_sh_q  <= 7'h00;
    end else begin
      rx_cnt_q <= rx_cnt_d;
      rx_sh_q  <= rx_sh_d;
    end
  end

  // Last complete command and its toggle survive select going high.
  always_comb begin
    cmd_d     = cmd_q;
    cmd_tog_d = cmd_tog_q;
    if (rx_done) begin
      cmd_d     = {rx_sh_q, din};
      cmd_tog_d = ~cmd_tog_q;
    end
  end

  always_ff @(posedge serial_shift_clock or posedge cfg_rst) begin
    if (cfg_rst) begin
      cmd_q     <= tass_pkg::CMD_RST;
      cmd_tog_q <= 1'b0;
    end else begin
      cmd_q     <= cmd_d;
      cmd_tog_q <= cmd_tog_d;
    end
  end

  // Readout on the falling edge; a new command restarts it.
  assign conv_start = seen_tog_q ^ cmd_tog_q;

  always_comb begin
    phase_d   = phase_q;
    fcnt_d    = fcnt_q;
    fsh_d     = fsh_q;
    diff_d    = diff_q;
    dout_d    = 1'b0;
    busy_d    = 1'b0;
    eoc_pulse = 1'b0;
    if (conv_start) begin
      phase_d = tass_pkg::TASS_BUSY;
      busy_d  = 1'b1;
      diff_d  = ~cmd_q.ref_mode_single_ended;
      fsh_d   = cmd_q.res_8bit ? {conv_code[11:4], 4'h0} : conv_code;
      fcnt_d  = cmd_q.res_8bit ? tass_pkg::BITS_LO : tass_pkg::BITS_HI;
    end else begin
      unique case (phase_q)
        tass_pkg::TASS_IDLE: begin
        end
        tass_pkg::TASS_BUSY: begin
          phase_d = tass_pkg::TASS_DATA;
          dout_d  = fsh_q[11];
          fsh_d   = {fsh_q[10:0], 1'b0};
        end
        tass_pkg::TASS_DATA: begin
          if (fcnt_q == tass_pkg::CNT_ZERO) begin
            phase_d = diff_q ? tass_pkg::TASS_TAIL : tass_pkg::TASS_IDLE;
          end else begin
            dout_d = fsh_q[11];
            fsh_d  = {fsh_q[10:0], 1'b0};
            fcnt_d = fcnt_q - tass_pkg::CNT_ONE;
            if (fcnt_q == tass_pkg::CNT_ONE) begin
              eoc_pulse = 1'b1;
            end
          end
        end
        tass_pkg::TASS_TAIL: begin
          phase_d = tass_pkg::TASS_IDLE;
        end
      endcase
    end
    meas_d = (phase_d != tass_pkg::TASS_IDLE) ||
             (rx_cnt_q >= tass_pkg::ACQ_AT);
  end

  always_ff @(negedge serial_shift_clock or posedge link_rst) begin
    if (link_rst) begin
      phase_q <= tass_pkg::TASS_IDLE;
      fcnt_q  <= tass_pkg::CNT_ZERO;
      fsh_q   <= 12'h000;
      diff_q  <= 1'b0;
      dout_q  <= 1'b0;
      busy_q  <= 1'b0;
      meas_q  <= 1'b0;
    end else begin
      phase_q <= phase_d;
      fcnt_q  <= fcnt_d;
      fsh_q   <= fsh_d;
      diff_q  <= diff_d;
      dout_q  <= dout_d;
      busy_q  <= busy_d;
      meas_q  <= meas_d;
    end
  end

  always_comb begin
    seen_tog_d = cmd_tog_q;
    eoc_tog_d  = eoc_tog_q ^ eoc_pulse;
  end

  always_ff @(negedge serial_shift_clock or posedge cfg_rst) begin
    if (cfg_rst) begin
      seen_tog_q <= 1'b0;
      eoc_tog_q  <= 1'b0;
    end else begin
      seen_tog_q <= seen_tog_d;
      eoc_tog_q  <= eoc_tog_d;
    end
  end

  assign dout      = dout_q;
  assign busy      = busy_q;
  assign dout_oe_n = cs_n;
  assign busy_oe_n = cs_n;

  // Crossing into the reference clock domain.
  always_comb begin
    sy_d           = '0;
    sy_d[tass_pkg::SY_CSN]   = cs_n;
    sy_d[tass_pkg::SY_TOUCH] = touch_sense;
    sy_d[tass_pkg::SY_MEAS]  = meas_q;
    sy_d[tass_pkg::SY_CMD]   = cmd_tog_q;
    sy_d[tass_pkg::SY_EOC]   = eoc_tog_q;
  end

  assign cs_s     = sy2_q[tass_pkg::SY_CSN];
  assign touch_s  = sy2_q[tass_pkg::SY_TOUCH];
  assign meas_s   = sy2_q[tass_pkg::SY_MEAS];
  assign cmd_evt  = sy2_q[tass_pkg::SY_CMD] ^ cmdt_q;
  assign eoc_evt  = sy2_q[tass_pkg::SY_EOC] ^ eoct_q;
  assign pos_chan = POS_CHAN_MASK[cap_q.channel_select];

  // Settings, pen sensing and analog controls.
  always_comb begin
    cap_d     = cap_q;
    pen_en_d  = pen_en_q;
    startup_d = startup_q;
    if (cmd_evt) begin
      cap_d    = cmd_q;
      pen_en_d = 1'b0;
      if (!cmd_q.adc_powerdown_sel) begin
        startup_d = 1'b0;
      end
    end
    if (eoc_evt && !cap_q.adc_powerdown_sel) begin
      pen_en_d = 1'b1;
    end
    if (meas_s) begin
      irq_d = pos_chan ? 1'b0 : 1'b1;
    end else if (pen_en_q) begin
      irq_d = touch_s;
    end else begin
      irq_d = 1'b1;
    end
    ana_d.xp_pullup_en = ~(meas_s & pos_chan);
    ana_d.ydrv_on      = ~meas_s & ~cs_s & ~startup_q &
                         ~cap_q.adc_powerdown_sel;
    ana_d.adc_on       = ~cs_s & (meas_s | startup_q |
                         cap_q.adc_powerdown_sel);
    ana_d.ref_on       = cap_q.ref_power_sel;
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      sy1_q     <= tass_pkg::SY_RST;
      sy2_q     <= tass_pkg::SY_RST;
      cmdt_q    <= 1'b0;
      eoct_q    <= 1'b0;
      cap_q     <= tass_pkg::CMD_RST;
      pen_en_q  <= 1'b0;
      startup_q <= 1'b1;
      irq_q     <= 1'b1;
      ana_q     <= '0;
    end else begin
      sy1_q     <= sy_d;
      sy2_q     <= sy1_q;
      cmdt_q    <= sy2_q[tass_pkg::SY_CMD];
      eoct_q    <= sy2_q[tass_pkg::SY_EOC];
      cap_q     <= cap_d;
      pen_en_q  <= pen_en_d;
      startup_q <= startup_d;
      irq_q     <= irq_d;
      ana_q     <= ana_d;
    end
  end

  assign pen_touch_irq_n       = irq_q;
  assign ana                   = ana_q;
  assign channel_select        = cap_q.channel_select;
  assign ref_mode_single_ended = cap_q.ref_mode_single_ended;

  ydrv_idle_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (!meas_s && !cs_s && !startup_q && !cap_q.adc_powerdown_sel)
    |=> ana.ydrv_on)
    else $error("Y driver not on while idle in auto power-down.");

  pen_touch_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (pen_en_q && !meas_s && !touch_s) |=> !pen_touch_irq_n)
    else $error("Touch did not pull the pen output low.");

  xp_open_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (meas_s && pos_chan) |=> !ana.xp_pullup_en)
    else $error("Pull-up left on during a position measurement.");

  pen_pos_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (meas_s && pos_chan) |=> !pen_touch_irq_n)
    else $error("Pen output not low during a position measurement.");

  pen_aux_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (meas_s && !pos_chan) |=> pen_touch_irq_n)
    else $error("Pen output not high during an auxiliary measurement.");

  pen_off_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (cmd_evt && !eoc_evt && cmd_q.adc_powerdown_sel) |=> !pen_en_q [*2])
    else $error("Pen sensing on after a full-power command.");

  pen_back_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(pen_en_q) |-> $past(eoc_evt) && !$past(cap_q.adc_powerdown_sel))
    else $error("Pen sensing returned without end of conversion.");

  cs_down_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    cs_s |=> !ana.adc_on && (ana.ref_on == $past(cap_q.ref_power_sel)))
    else $error("Converter powered or reference changed with select high.");

  startup_on_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (startup_q && !cs_s) |=> ana.adc_on)
    else $error("Converter off before the first auto power-down command.");

  busy_pulse_a: assert property (@(negedge serial_shift_clock)
    disable iff (link_rst)
    busy_q |=> !busy_q && (phase_q == tass_pkg::TASS_DATA))
    else $error("Busy did not fall into the readout.");

endmodule : tass_core

// ===== dv/tass_host_model.sv
/*
  Host serial master model for the touch converter sequencer.
  Assumes the bench calls its tasks; link clock period 64 ns.
*/
`timescale 1ns/1ps
module tass_host_model (
  output logic      serial_shift_clock,
  output logic      cs_n,
  output logic      din,
  input  wire logic dout
);
  logic [63:0] tx_q;
  logic [63:0] rx_q;
  logic        irq_mask;

  // Clock stands high and select low while the device powers up.
  initial begin
    serial_shift_clock = 1'b1;
    cs_n               = 1'b0;
    din                = 1'b0;
    irq_mask           = 1'b0;
    tx_q               = 64'h0;
    rx_q               = 64'h0;
  end

  task automatic frame(input logic [63:0] pattern);
    irq_mask           = 1'b1;
    serial_shift_clock = 1'b0;
    cs_n = 1'b0;
    tx_q = pattern;
    rx_q = 64'h0;
    #100;
  endtask : frame

  // Clock stands still outside calls; each frame ends far inside 1.6ms.
  task automatic clocks(input int n);
    for (int i = 0; i < n; i++) begin
      din  = tx_q[63];
      tx_q = {tx_q[62:0], 1'b0};
      #32;
      rx_q = {rx_q[62:0], dout};
      serial_shift_clock = 1'b1;
      #32;
      serial_shift_clock = 1'b0;
    end
  endtask : clocks

  task automatic release_bus();
    #32;
    din  = ~din;
    cs_n = 1'b1;
    #100;
    irq_mask = 1'b0;
  endtask : release_bus
endmodule : tass_host_model

// ===== dv/test_touch_adc_serial_sequencer.sv
/*
  Self-checking bench for the touch converter sequencer.
  Assumes the core and the host model; ref_clk 100 ns.
*/
`timescale 1ns/1ps
module test_touch_adc_serial_sequencer;
  logic                ref_clk     = 1'b0;
  logic                resetn;
  logic                touch_sense;
  logic [11:0]         conv_code;
  logic                serial_shift_clock;
  logic                cs_n;
  logic                din;
  logic                dout;
  logic                dout_oe_n;
  logic                busy;
  logic                busy_oe_n;
  logic                pen_touch_irq_n;
  tass_pkg::tass_ana_t ana;
  logic [2:0]          channel_select;
  logic                ref_mode_single_ended;
  int                  mismatches = 0;
  int                  tests_run  = 0;
  int                  unmasked_falls = 0;

  always #50 ref_clk = ~ref_clk;

  // A pen interrupt may only fall while the host has it masked.
  always @(negedge pen_touch_irq_n) begin
    if (!host.irq_mask) begin
      unmasked_falls++;
    end
  end

  tass_core dut (
    .ref_clk              (ref_clk),
    .resetn               (resetn),
    .serial_shift_clock   (serial_shift_clock),
    .cs_n                 (cs_n),
    .din                  (din),
    .touch_sense          (touch_sense),
    .conv_code            (conv_code),
    .dout                 (dout),
    .dout_oe_n            (dout_oe_n),
    .busy                 (busy),
    .busy_oe_n            (busy_oe_n),
    .pen_touch_irq_n      (pen_touch_irq_n),
    .ana                  (ana),
    .channel_select       (channel_select),
    .ref_mode_single_ended(ref_mode_single_ended)
  );

  tass_host_model host (
    .serial_shift_clock(serial_shift_clock),
    .cs_n              (cs_n),
    .din               (din),
    .dout              (dout)
  );

  task automatic chk_bit(input string what, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit

  task automatic chk_word(input string what, input logic [63:0] exp,
                          input logic [63:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_word

  task automatic settle();
    repeat (8) @(posedge ref_clk);
    #10;
  endtask : settle

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up

  // Two back-to-back conversions, second start bit gap clocks after first.
  function automatic logic [63:0] two_conv(input logic res8, input int gap);
    int          last;
    logic [63:0] r;
    last = res8 ? 17 : 21;
    r    = res8 ? 64'(conv_code[11:4]) : 64'(conv_code);
    return (r << (gap + 24 - last)) | (r << (24 - last));
  endfunction : two_conv

  task automatic cadence(input logic [7:0] cmd, input int gap);
    host.frame({cmd, 56'h0} | (64'(cmd) << (56 - gap)));
    host.clocks(gap + 24);
    chk_word("cadence", two_conv(cmd[3], gap), host.rx_q);
    host.release_bus();
    chk_bit("single", cmd[2], ref_mode_single_ended);
    $display("test cadence %0d done", gap);
  endtask : cadence

  initial begin
    repeat (3000) @(posedge ref_clk);
    mismatches++;
    wrap_up();
  end

  initial begin
    resetn      <= 1'b0;
    touch_sense <= 1'b1;
    conv_code   <= 12'hA5C;
    repeat (20) @(posedge ref_clk);
    resetn <= 1'b1;
    settle();
    chk_bit("irq", 1'b1, pen_touch_irq_n);
    chk_bit("adc_on", 1'b1, ana.adc_on);
    chk_bit("dout", 1'b0, dout);
    $display("test startup done");

    host.frame({8'h94, 56'h0});
    host.clocks(8);
    #10;
    chk_bit("busy", 1'b1, busy);
    chk_bit("oe", 1'b0, dout_oe_n);
    host.clocks(4);
    settle();
    chk_bit("irq", 1'b0, pen_touch_irq_n);
    chk_bit("pullup", 1'b0, ana.xp_pullup_en);
    chk_bit("adc_on", 1'b1, ana.adc_on);
    host.clocks(12);
    settle();
    chk_word("result", 64'(conv_code) << 3, host.rx_q);
    chk_word("channel", 64'h1, 64'(channel_select));
    chk_bit("single", 1'b1, ref_mode_single_ended);
    chk_bit("adc_on", 1'b0, ana.adc_on);
    chk_bit("ydrv", 1'b1, ana.ydrv_on);
    chk_bit("irq", 1'b1, pen_touch_irq_n);
    @(posedge ref_clk);
    touch_sense <= 1'b0;
    settle();
    chk_bit("irq", 1'b0, pen_touch_irq_n);
    $display("test position done");

    host.frame({8'hA4, 56'h0});
    host.clocks(12);
    settle();
    chk_bit("irq", 1'b1, pen_touch_irq_n);
    host.clocks(12);
    settle();
    chk_bit("irq", 1'b0, pen_touch_irq_n);
    $display("test auxiliary done");

    host.frame({8'hA7, 56'h0});
    host.clocks(24);
    settle();
    chk_bit("irq", 1'b1, pen_touch_irq_n);
    chk_bit("adc_on", 1'b1, ana.adc_on);
    chk_bit("ref_on", 1'b1, ana.ref_on);
    $display("test full power done");

    host.frame({8'h96, 56'h0});
    host.clocks(12);
    host.release_bus();
    settle();
    chk_bit("adc_on", 1'b0, ana.adc_on);
    chk_bit("ref_on", 1'b1, ana.ref_on);
    chk_bit("oe", 1'b1, busy_oe_n);
    chk_bit("irq", 1'b1, pen_touch_irq_n);
    host.frame({8'hA8, 56'h0});
    host.clocks(5);
    host.release_bus();
    settle();
    chk_word("channel", 64'h1, 64'(channel_select));
    $display("test abort done");

    @(posedge ref_clk);
    conv_code <= 12'h3C9;
    cadence(8'hD7, 15);
    cadence(8'hD3, 16);
    cadence(8'hD7, 24);
    @(posedge ref_clk);
    conv_code <= 12'h6E1;
    cadence(8'hDF, 11);
    cadence(8'hDB, 16);
    chk_word("unmasked falls", 64'h0, 64'(unmasked_falls));
    wrap_up();
  end
endmodule : test_touch_adc_serial_sequencer
